// ==== core/arcc_defs.svh ====
// Constants for the autoreload timer capture/compare block
`ifndef ARCC_DEFS_SVH
`define ARCC_DEFS_SVH
// ==========================================================
// Register offsets (own map)
`define ARCC_A_CTRL     5'h00
`define ARCC_A_CTRL2    5'h01
`define ARCC_A_RLD1     5'h02
`define ARCC_A_RLD2     5'h03
`define ARCC_A_DUTY0    5'h04
`define ARCC_A_CAPT     5'h08
`define ARCC_A_CNT1     5'h09
`define ARCC_A_CNT2     5'h0A
`define ARCC_A_SS       5'h0B
`define ARCC_A_FLAGS    5'h0C
// ==========================================================
// Field positions
`define ARCC_B_CAPIE    0
`define ARCC_B_COMPARE_IRQ_ENABLE    1
`define ARCC_B_CK       2
`define ARCC_B_CNT2EN   4
`define ARCC_B_SRC      5
`define ARCC_B_TRAN1    0
`define ARCC_B_TRAN2    1
`define ARCC_B_FORCED_OVERFLOW_ONE   2
`define ARCC_B_FORCED_OVERFLOW_TWO   3
`define ARCC_B_SSEN     0
`define ARCC_B_SSEDGE   1
`define ARCC_B_POL2     2
`define ARCC_B_POL3     3
// ==========================================================
// Values
`define ARCC_CK_LITE    2'h1
`define ARCC_CNT_MAX    12'hFFF
`define ARCC_CNT_ZERO   12'h000
`define ARCC_SS_DLY     2'h2
`endif

// ==== core/arcc_pkg.sv ====
// Types for the autoreload timer capture/compare block
package arcc_pkg;
   typedef struct packed {
      logic       capt_flag;
      logic [3:0] cmp_flag;
      logic       overflow_flag_two;
   } arcc_flags_t;
   typedef enum logic [1:0] {
      ARCC_SS_IDLE = 2'b00,
      ARCC_SS_WAIT = 2'b01,
      ARCC_SS_PULS = 2'b10
   } arcc_ss_t;
endpackage

// ==== core/arcc_timer.sv ====
// Autoreload timer capture, compare, single-shot and forced overflow
// Function
// - Counter one matching active duty sets compare flag, interrupt if enabled.
// - Single mode: counter one vs four channels; dual: channels split by counter.
// - Zero active duty value never produces a compare event.
// - Preload duty copies to active only at overflow with transfer enabled.
// - Capture edge latches counter one, sets capture flag, interrupt if enabled.
// - Reading capture value clears flag; writes cannot change the flag.
// - New capture edges ignored while capture flag set.
// - Lite tick clocks counter one; source select routes lite capture pin.
// - Single-shot only in dual mode, on counter two, edge polarity selectable.
// - Active edge clears counter two, output three high until duty match.
// - Without edge, counter two reloads at reload value, output high again.
// - Output two follows single-shot using channel 2 duty.
// - Single-shot enable and edge take effect immediately.
// - Polarity of outputs two and three updates at overflow with transfer.
// - Output three priority: break, edge shot, force, shot, normal PWM.
// - Counter two reset in single-shot raises overflow interrupt.
// - Break resets counter two; in single-shot mode it also resets duty 2 and 3 and reload two.
// - Forced overflow loads FFFh, then counter continues from reload, or from zero for counter two in single-shot; bit clears.
// - Halt stops the counter.
//
// Implementation choices: strobed register access and the placing of the registers.
`include "arcc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module arcc_timer
   import arcc_pkg::*;
#(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Register port
   input  wire logic [4:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // Counter clock ticks
   input  wire logic        tick_cpu,
   input  wire logic        tick_fast,
   input  wire logic        tick_lite,
   // Pins and system
   input  wire logic        capture_pin,
   input  wire logic        lite_capture_pin,
   input  wire logic        brk_one,
   input  wire logic        brk_two,
   input  wire logic        halt,
   // Outputs
   output logic             pwm_out_two,
   output logic             pwm_out_three,
   output logic             cmp_irq,
   output logic             capt_irq,
   output logic             overflow_flag_two_irq
);
   // ==========================================================
   // Registers
   logic [1:0]   counter_clock_select;
   logic         capture_irq_enable, compare_irq_enable;
   logic         second_counter_enable, capture_source_select;
   logic [1:0]   transfer_enable;
   logic         forced_overflow_one, forced_overflow_two;
   logic         single_shot_enable, single_shot_edge;
   logic [3:2]   output_polarity, pol_act;
   logic [W-1:0] reload_value_one, reload_value_two;
   logic [W-1:0] counter_one, counter_two, capture_value_reg;
   logic [W-1:0] duty_pre [4];
   logic [W-1:0] duty_act [4];
   arcc_flags_t  flg;
   logic [2:0]   cap_sy, lit_sy;
   logic         cap_lv, lit_lv;
   arcc_ss_t     ss_st;
   logic [1:0]   ss_dly;
   logic         pend_shot;

   function automatic logic wr_at(input logic [4:0] a);
      return wr && addr == a;
   endfunction
   function automatic logic hit(input logic [W-1:0] c, input logic [W-1:0] d);
      return d != `ARCC_CNT_ZERO && c == d;
   endfunction

   // ==========================================================
   // Counter clocks and events
   logic tick1, tick2, ovf1, overflow_flag_two, ss_mode, shot_rst, cap_edge, lit_edge, ss_edge;
   always_comb begin
      unique case (counter_clock_select)
         2'b00: tick1 = 1'b0;
         2'b01: tick1 = tick_lite;
         2'b10: tick1 = tick_cpu;
         2'b11: tick1 = tick_fast;
      endcase
      tick1 = tick1 && !halt;
   end
   // Counter two freezes in break, so a cleared reload cannot spin overflows
   assign tick2    = tick1 && second_counter_enable && !brk_two;
   assign ss_mode  = single_shot_enable && second_counter_enable;
   assign ovf1     = tick1 && counter_one == `ARCC_CNT_MAX;
   assign shot_rst = tick2 && ss_mode && pend_shot && ss_dly == `ARCC_SS_DLY;
   assign overflow_flag_two     = tick2 && (counter_two == `ARCC_CNT_MAX
                     || (ss_mode && counter_two == reload_value_two) || shot_rst);
   // three-stage sync, second and third agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cap_sy <= 3'h0;
         lit_sy <= 3'h0;
         cap_lv <= 1'b0;
         lit_lv <= 1'b0;
      end else begin
         cap_sy <= {cap_sy[1:0], capture_pin};
         lit_sy <= {lit_sy[1:0], lite_capture_pin};
         if (cap_sy[2] == cap_sy[1]) cap_lv <= cap_sy[2];
         if (lit_sy[2] == lit_sy[1]) lit_lv <= lit_sy[2];
      end
   end
   logic src_nx, lit_nx;
   assign src_nx  = cap_sy[2] == cap_sy[1] ? cap_sy[2] : cap_lv;
   assign cap_edge = src_nx != cap_lv;
   assign lit_nx  = lit_sy[2] == lit_sy[1] ? lit_sy[2] : lit_lv;
   assign lit_edge = lit_nx != lit_lv;
   assign ss_edge  = lit_edge && (lit_nx == single_shot_edge);
   logic capt_ev;
   assign capt_ev = capture_source_select ? lit_edge : cap_edge;

   // ==========================================================
   // Counter one and forced overflow one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         counter_one         <= `ARCC_CNT_ZERO;
         forced_overflow_one <= 1'b0;
      end else if (brk_one) begin
         counter_one <= `ARCC_CNT_ZERO;
      end else begin
         if (wr_at(`ARCC_A_CTRL2) && wdata[`ARCC_B_FORCED_OVERFLOW_ONE]) begin
            forced_overflow_one <= 1'b1;
            counter_one         <= `ARCC_CNT_MAX;
         end else if (ovf1) begin
            counter_one         <= reload_value_one;
            forced_overflow_one <= 1'b0;
         end else if (tick1) begin
            counter_one <= counter_one + 1'b1;
         end
      end
   end

   // ==========================================================
   // Counter two, single-shot sequencing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         counter_two         <= `ARCC_CNT_ZERO;
         forced_overflow_two <= 1'b0;
         pend_shot           <= 1'b0;
         ss_dly              <= 2'h0;
         ss_st               <= ARCC_SS_IDLE;
      end else if (brk_two) begin
         counter_two <= `ARCC_CNT_ZERO;
         pend_shot   <= 1'b0;
         ss_st       <= ARCC_SS_IDLE;
      end else begin
         if (ss_mode && ss_edge && ss_st != ARCC_SS_PULS && !pend_shot) begin
            pend_shot <= 1'b1;
            ss_dly    <= 2'h0;
         end else if (pend_shot && tick2 && ss_dly != `ARCC_SS_DLY) begin
            ss_dly <= ss_dly + 2'h1;
         end
         if (!ss_mode) pend_shot <= 1'b0;
         if (shot_rst) begin
            counter_two <= `ARCC_CNT_ZERO;
            pend_shot   <= 1'b0;
            ss_st       <= ARCC_SS_PULS;
         end else if (wr_at(`ARCC_A_CTRL2) && wdata[`ARCC_B_FORCED_OVERFLOW_TWO]) begin
            forced_overflow_two <= 1'b1;
            counter_two         <= `ARCC_CNT_MAX;
         end else if (overflow_flag_two) begin
            counter_two         <= ss_mode ? `ARCC_CNT_ZERO : reload_value_two;
            forced_overflow_two <= 1'b0;
            ss_st               <= ss_mode ? ARCC_SS_WAIT : ARCC_SS_IDLE;
         end else if (tick2) begin
            counter_two <= counter_two + 1'b1;
            if (hit(counter_two, duty_act[3])) ss_st <= ARCC_SS_IDLE;
         end
      end
   end

   // ==========================================================
   // Duty, reload and polarity transfer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            duty_pre[i] <= `ARCC_CNT_ZERO;
            duty_act[i] <= `ARCC_CNT_ZERO;
         end
         reload_value_one <= `ARCC_CNT_ZERO;
         reload_value_two <= `ARCC_CNT_ZERO;
         pol_act          <= 2'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_at(5'(`ARCC_A_DUTY0 + i))) duty_pre[i] <= wdata[W-1:0];
            if (i < 2 || !second_counter_enable) begin
               if (ovf1 && transfer_enable[0]) duty_act[i] <= duty_pre[i];
            end else if (overflow_flag_two && transfer_enable[1]) begin
               duty_act[i] <= duty_pre[i];
            end
         end
         if (overflow_flag_two && transfer_enable[1]) pol_act <= output_polarity;
         if (wr_at(`ARCC_A_RLD1)) reload_value_one <= wdata[W-1:0];
         if (wr_at(`ARCC_A_RLD2)) reload_value_two <= wdata[W-1:0];
         if (brk_two && ss_mode) begin
            reload_value_two <= `ARCC_CNT_ZERO;
            for (int i = 2; i < 4; i++) begin
               duty_pre[i] <= `ARCC_CNT_ZERO;
               duty_act[i] <= `ARCC_CNT_ZERO;
            end
         end
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         counter_clock_select  <= 2'h0;
         capture_irq_enable    <= 1'b0;
         compare_irq_enable    <= 1'b0;
         second_counter_enable <= 1'b0;
         capture_source_select <= 1'b0;
         transfer_enable       <= 2'h3;
         single_shot_enable    <= 1'b0;
         single_shot_edge      <= 1'b0;
         output_polarity       <= 2'h0;
      end else begin
         if (wr_at(`ARCC_A_CTRL)) begin
            capture_irq_enable    <= wdata[`ARCC_B_CAPIE];
            compare_irq_enable    <= wdata[`ARCC_B_COMPARE_IRQ_ENABLE];
            counter_clock_select  <= wdata[`ARCC_B_CK +: 2];
            second_counter_enable <= wdata[`ARCC_B_CNT2EN];
            capture_source_select <= wdata[`ARCC_B_SRC];
         end
         if (wr_at(`ARCC_A_CTRL2)) transfer_enable <= wdata[`ARCC_B_TRAN1 +: 2];
         if (wr_at(`ARCC_A_SS)) begin
            single_shot_enable <= wdata[`ARCC_B_SSEN];
            single_shot_edge   <= wdata[`ARCC_B_SSEDGE];
            output_polarity    <= wdata[`ARCC_B_POL2 +: 2];
         end
      end
   end

   // ==========================================================
   // Capture, compare and overflow flags
   logic [3:0] cmp_hit;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         cmp_hit[i] = (i < 2 || !second_counter_enable)
                      ? tick1 && hit(counter_one, duty_act[i])
                      : tick2 && hit(counter_two, duty_act[i]);
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flg               <= '0;
         capture_value_reg <= `ARCC_CNT_ZERO;
      end else begin
         if (rd && addr == `ARCC_A_CAPT) flg.capt_flag <= 1'b0;
         if (capt_ev && !flg.capt_flag) begin
            flg.capt_flag     <= 1'b1;
            capture_value_reg <= counter_one;
         end
         if (rd && addr == `ARCC_A_FLAGS) begin
            flg.cmp_flag <= cmp_hit;
            flg.overflow_flag_two     <= overflow_flag_two;
         end else begin
            flg.cmp_flag <= flg.cmp_flag | cmp_hit;
            flg.overflow_flag_two     <= flg.overflow_flag_two | overflow_flag_two;
         end
      end
   end

   // ==========================================================
   // Outputs two and three
   logic next_p2, next_p3;
   always_comb begin
      next_p2 = pwm_out_two ^ pol_act[2];
      next_p3 = pwm_out_three ^ pol_act[3];
      if (brk_two) begin
         next_p2 = 1'b0;
         next_p3 = 1'b0;
      end else if (shot_rst) begin
         next_p2 = 1'b1;
         next_p3 = 1'b1;
      end else if (overflow_flag_two) begin
         next_p2 = 1'b1;
         next_p3 = 1'b1;
      end else if (tick2) begin
         if (hit(counter_two, duty_act[2])) next_p2 = 1'b0;
         if (hit(counter_two, duty_act[3])) next_p3 = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwm_out_two   <= 1'b0;
         pwm_out_three <= 1'b0;
         cmp_irq       <= 1'b0;
         capt_irq      <= 1'b0;
         overflow_flag_two_irq      <= 1'b0;
         rdata         <= 16'h0000;
      end else begin
         // Break level is fixed low whatever the polarity setting
         pwm_out_two   <= brk_two ? 1'b0 : next_p2 ^ pol_act[2];
         pwm_out_three <= brk_two ? 1'b0 : next_p3 ^ pol_act[3];
         cmp_irq       <= compare_irq_enable && |flg.cmp_flag;
         capt_irq      <= capture_irq_enable && flg.capt_flag;
         overflow_flag_two_irq      <= flg.overflow_flag_two;
         rdata         <= 16'h0000;
         if (rd) begin
            unique case (addr)
               `ARCC_A_CTRL:  rdata <= 16'({capture_source_select, second_counter_enable,
                                counter_clock_select, compare_irq_enable, capture_irq_enable});
               `ARCC_A_CTRL2: rdata <= 16'({forced_overflow_two, forced_overflow_one, transfer_enable});
               `ARCC_A_RLD1:  rdata <= 16'(reload_value_one);
               `ARCC_A_RLD2:  rdata <= 16'(reload_value_two);
               `ARCC_A_CAPT:  rdata <= 16'(capture_value_reg);
               `ARCC_A_CNT1:  rdata <= 16'(counter_one);
               `ARCC_A_CNT2:  rdata <= 16'(counter_two);
               `ARCC_A_SS:    rdata <= 16'({output_polarity, single_shot_edge, single_shot_enable});
               `ARCC_A_FLAGS: rdata <= 16'(flg);
               default:       rdata <= (addr[4:2] == 3'h1) ? 16'(duty_pre[addr[1:0]]) : 16'h0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Checks
   a_capt_hold: assert property (@(posedge clk) disable iff (!nrst)
      flg.capt_flag && !(rd && addr == `ARCC_A_CAPT) |=> $stable(capture_value_reg))
      else $error("capture value changed while flag set");
   a_capt_clear: assert property (@(posedge clk) disable iff (!nrst)
      rd && addr == `ARCC_A_CAPT && !capt_ev |=> !flg.capt_flag)
      else $error("capture flag not cleared by read");
   a_halt_stop: assert property (@(posedge clk) disable iff (!nrst)
      halt && !wr && !brk_one |=> $stable(counter_one))
      else $error("counter moved in halt");
   a_force_load: assert property (@(posedge clk) disable iff (!nrst)
      wr_at(`ARCC_A_CTRL2) && wdata[`ARCC_B_FORCED_OVERFLOW_ONE] && !brk_one |=> counter_one == `ARCC_CNT_MAX)
      else $error("forced overflow did not load max");
   a_shot_reset: assert property (@(posedge clk) disable iff (!nrst)
      shot_rst && !brk_two && !wr |=> counter_two == `ARCC_CNT_ZERO && flg.overflow_flag_two)
      else $error("single-shot reset missing");
   a_brk_low: assert property (@(posedge clk) disable iff (!nrst)
      brk_two |=> !pwm_out_two && !pwm_out_three)
      else $error("outputs not low in break");
   a_cmp_flag: assert property (@(posedge clk) disable iff (!nrst)
      tick1 && duty_act[0] != `ARCC_CNT_ZERO && counter_one == duty_act[0] |=> flg.cmp_flag[0])
      else $error("compare flag not set on match");
   a_force_clear: assert property (@(posedge clk) disable iff (!nrst)
      ovf1 && !brk_one && !(wr_at(`ARCC_A_CTRL2) && wdata[`ARCC_B_FORCED_OVERFLOW_ONE]) |=> !forced_overflow_one)
      else $error("forced overflow bit not cleared");
   a_shot_high: assert property (@(posedge clk) disable iff (!nrst)
      shot_rst && !brk_two |=> pwm_out_three == !$past(pol_act[3]))
      else $error("output three not raised by shot");
   a_cap_pulse: assert property (@(posedge clk) disable iff (!nrst)
      cap_edge |=> !cap_edge)
      else $error("capture edge longer than one cycle");
   a_lite_pulse: assert property (@(posedge clk) disable iff (!nrst)
      lit_edge |=> !lit_edge)
      else $error("lite edge longer than one cycle");
endmodule
`default_nettype wire

// ==== testbench/arcc_pins_model.sv ====
// Partner model driving the capture pin and the lite timer capture pin
`timescale 1ns/100ps
`default_nettype none
module arcc_pins_model (
   // Clock
   input  wire logic clk,
   // Toggle requests from the bench
   input  wire logic tog_capt,
   input  wire logic tog_lite,
   // Pins towards the timer
   output logic      capture_pin,
   output logic      lite_capture_pin
);
   // ==========================================================
   // Pin drivers
   logic cap_lvl = 1'b0;
   logic lit_lvl = 1'b0;
   always @(posedge clk) begin
      if (tog_capt) begin
         cap_lvl <= ~cap_lvl;
      end
      if (tog_lite) begin
         lit_lvl <= ~lit_lvl;
      end
   end
   // Pins move 3 ns after the edge: an outside source has no tie to our clock
   assign #3 capture_pin      = cap_lvl;
   assign #3 lite_capture_pin = lit_lvl;
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the autoreload timer capture/compare block
`include "arcc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk, nrst, wr, rd, tick_cpu, tick_fast, tick_lite, brk_one, brk_two, halt;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, v, c;
   logic        capture_pin, lite_capture_pin, pwm_out_two, pwm_out_three;
   logic        cmp_irq, capt_irq, overflow_flag_two_irq, tog_capt, tog_lite;
   logic [11:0] d3;
   int          fail_count, n_checks, seed, hi, per, n;
   // ==========================================================
   // Design and partner
   arcc_timer arcc_timer_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .tick_cpu(tick_cpu), .tick_fast(tick_fast), .tick_lite(tick_lite),
      .capture_pin(capture_pin), .lite_capture_pin(lite_capture_pin), .brk_one(brk_one),
      .brk_two(brk_two), .halt(halt), .pwm_out_two(pwm_out_two), .pwm_out_three(pwm_out_three),
      .cmp_irq(cmp_irq), .capt_irq(capt_irq), .overflow_flag_two_irq(overflow_flag_two_irq));
   arcc_pins_model arcc_pins_model_i (.clk(clk), .tog_capt(tog_capt), .tog_lite(tog_lite),
      .capture_pin(capture_pin), .lite_capture_pin(lite_capture_pin));
   // ==========================================================
   // Clock and random ticks
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Fast tick is never selected here, so it must never move a counter
   always @(posedge clk) begin
      tick_fast <= 1'($random(seed));
      tick_lite <= 1'($random(seed));
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic near(input string nm, input int seen, input int lo, input int hi_b);
      chk(nm, 16'((seen >= lo && seen <= hi_b) ? lo : seen), 16'(lo));
   endtask
   // Every access costs two cycles so no strobe is assigned twice in a step
   task automatic acc(input logic [4:0] a, input logic [15:0] d, input logic w);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= ~w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [15:0] m, input string nm, input logic [15:0] e);
      acc(a, 16'h0000, 1'b0);
      chk(nm, v & m, e);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic tog(input bit l);
      if (l) begin
         tog_lite <= 1'b1;
      end else begin
         tog_capt <= 1'b1;
      end
      @(posedge clk);
      tog_lite <= 1'b0;
      tog_capt <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic pw(input bit s);
      return s ? pwm_out_three : pwm_out_two;
   endfunction
   // Counts negedge samples while the output holds lvl, bounded
   task automatic meas(input bit s, input logic lvl, output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (pw(s) === lvl && k < 300);
      // Back onto the rising edge so the next request starts there
      @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Watchdog, about ten times the expected run
   initial begin
      #(20 * 60000);
      fail_count++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'hB80D;
      {nrst, wr, rd, halt, brk_one, brk_two, tog_capt, tog_lite} = '0;
      tick_cpu = 1'b1;
      addr = 5'h00;
      wdata = 16'h0000;
      fail_count = 0;
      n_checks = 0;
      cyc(12);
      nrst <= 1'b1;
      cyc(1);
      rdc(`ARCC_A_CNT1, 16'hFFFF, "cnt1_rst", 16'h0000);
      rdc(`ARCC_A_CTRL2, 16'hFFFF, "ctrl2_rst", 16'h0003);
      rdc(5'h1F, 16'hFFFF, "unmapped", 16'h0000);
      halt <= 1'b1;
      acc(`ARCC_A_CTRL, 16'h000B, 1'b1);
      cyc(10);
      rdc(`ARCC_A_CNT1, 16'hFFFF, "cnt1_halt", 16'h0000);
      halt <= 1'b0;
      acc(`ARCC_A_CNT1, 16'h0000, 1'b0);
      c = v;
      cyc(10);
      rdc(`ARCC_A_CNT1, 16'hFFFF, "cnt1_run", c + 16'h000C);
      // Full wrap through zero with all active duties still zero
      cyc(4200);
      rdc(`ARCC_A_FLAGS, 16'h001E, "cmp_zero", 16'h0000);
      acc(`ARCC_A_CTRL2, 16'h0000, 1'b1);
      acc(`ARCC_A_RLD1, 16'h0F00, 1'b1);
      for (int i = 0; i < 4; i++) begin
         acc(`ARCC_A_DUTY0 + 5'(i), 16'h0F10 + 16'($random(seed) & 8'hDF), 1'b1);
      end
      acc(`ARCC_A_CTRL2, 16'h0004, 1'b1);
      cyc(300);
      rdc(`ARCC_A_FLAGS, 16'h001E, "cmp_no_tran", 16'h0000);
      acc(`ARCC_A_CTRL2, 16'h0007, 1'b1);
      rdc(`ARCC_A_CTRL2, 16'hFFFF, "force_clr", 16'h0003);
      rdc(`ARCC_A_CNT1, 16'hFF00, "cnt1_reload", 16'h0F00);
      cyc(300);
      chk("cmp_irq", {15'h0000, cmp_irq}, 16'h0001);
      rdc(`ARCC_A_FLAGS, 16'h001E, "cmp_all", 16'h001E);
      // Capture, then a second edge while the flag is still up
      acc(`ARCC_A_CNT1, 16'h0000, 1'b0);
      c = v;
      tog(1'b0);
      cyc(20);
      chk("capt_irq", {15'h0000, capt_irq}, 16'h0001);
      tog(1'b0);
      cyc(20);
      rdc(`ARCC_A_FLAGS, 16'h0020, "capt_flag", 16'h0020);
      acc(`ARCC_A_CAPT, 16'h0000, 1'b0);
      n = (v >= c) ? v - c : v + 256 - c;
      near("capt_val", n, 2, 16);
      rdc(`ARCC_A_FLAGS, 16'h0020, "capt_clr", 16'h0000);
      acc(`ARCC_A_FLAGS, 16'hFFFF, 1'b1);
      rdc(`ARCC_A_FLAGS, 16'h0020, "capt_wr", 16'h0000);
      // Source change in the safe order, then lite clocking
      acc(`ARCC_A_CTRL, 16'h000A, 1'b1);
      acc(`ARCC_A_CTRL, 16'h002A, 1'b1);
      acc(`ARCC_A_CAPT, 16'h0000, 1'b0);
      acc(`ARCC_A_CTRL, 16'h0027, 1'b1);
      tog(1'b0);
      cyc(30);
      chk("capt_src", {15'h0000, capt_irq}, 16'h0000);
      tog(1'b1);
      cyc(30);
      chk("capt_lite", {15'h0000, capt_irq}, 16'h0001);
      acc(`ARCC_A_CAPT, 16'h0000, 1'b0);
      // Single-shot on counter two, reload above both duties
      acc(`ARCC_A_CTRL, 16'h0018, 1'b1);
      acc(`ARCC_A_RLD2, 16'h0040, 1'b1);
      acc(`ARCC_A_DUTY0 + 5'h02, 16'h0010, 1'b1);
      d3 = 12'h020 + 12'($random(seed) & 3'h7);
      acc(`ARCC_A_DUTY0 + 5'h03, {4'h0, d3}, 1'b1);
      acc(`ARCC_A_SS, 16'h0003, 1'b1);
      acc(`ARCC_A_CTRL2, 16'h000B, 1'b1);
      for (int s = 0; s < 2; s++) begin
         meas(s == 1, 1'b1, hi);
         meas(s == 1, 1'b0, hi);
         meas(s == 1, 1'b1, hi);
         meas(s == 1, 1'b0, per);
         near("shot_hi", hi, (s == 1) ? d3 - 1 : 15, (s == 1) ? d3 + 1 : 17);
         near("shot_per", hi + per, 64, 66);
      end
      // Active edge early in the low phase, another during the pulse
      meas(1'b1, 1'b1, hi);
      cyc(2);
      acc(`ARCC_A_FLAGS, 16'h0000, 1'b0);
      tog(1'b1);
      tog(1'b1);
      meas(1'b1, 1'b0, n);
      near("shot_dly", n, 2, 9);
      tog(1'b1);
      tog(1'b1);
      meas(1'b1, 1'b1, hi);
      near("shot_ign", hi + 4, d3 - 1, d3 + 1);
      chk("overflow_flag_two_irq", {15'h0000, overflow_flag_two_irq}, 16'h0001);
      rdc(`ARCC_A_FLAGS, 16'h0001, "overflow_flag_two_edge", 16'h0001);
      brk_two <= 1'b1;
      cyc(4);
      chk("brk_pwm", {14'h0000, pwm_out_three, pwm_out_two}, 16'h0000);
      rdc(`ARCC_A_CNT2, 16'hFFFF, "brk_cnt2", 16'h0000);
      rdc(`ARCC_A_RLD2, 16'hFFFF, "brk_rld2", 16'h0000);
      rdc(`ARCC_A_DUTY0 + 5'h03, 16'hFFFF, "brk_duty3", 16'h0000);
      brk_two <= 1'b0;
      cyc(4);
      print_verdict();
   end
endmodule
`default_nettype wire
